/* File: pkg/dmcs_pkg.sv */
// Purpose: shared constants and types for the dma event and security block
// Assumes: eight channels, 32-bit byte addresses
// Notes:   area select n gives a wrap window of 2**n bytes, 0 switches it off

package dmcs_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int NCH    = 8;
   localparam int CHW    = 3;
   localparam int AW     = 32;
   localparam int CW     = 16;  // transfer counter width
   localparam int SW     = 11;  // repeat or block span, 1 to 1024
   localparam int ARW    = 5;   // area select width

   // ---------------------------------------------------------------
   // limits and reset values
   // ---------------------------------------------------------------
   localparam logic [ARW-1:0] AREA_MAX  = 5'h1B;   // 2**27 bytes = 128 Mbytes
   localparam logic [SW-1:0]  SPAN_MAX  = 11'h400; // 1024 units
   localparam logic [SW-1:0]  SPAN_ONE  = 11'h001;
   localparam logic [CW-1:0]  CNT_ONE   = 16'h0001;
   localparam logic [CW-1:0]  CNT_RST   = 16'h0000;
   localparam logic [SW-1:0]  SPAN_RST  = 11'h000;
   localparam logic [AW-1:0]  ADDR_RST  = 32'h0000_0000;

   // ---------------------------------------------------------------
   // modes and channel states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_REPEAT = 2'h1,
      MODE_BLOCK  = 2'h2
   } dmcs_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_RUN  = 3'h2,
      ST_HALT = 3'h4
   } dmcs_state_t;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      dmcs_mode_t     mode;
      logic           freeRun;     // no transfer end
      logic           repeatSrc;   // repeat side: 1 source, 0 destination
      logic           secure;      // channel security attribute
      logic [CW-1:0]  count;       // units, or blocks in block mode
      logic [SW-1:0]  span;        // repeat size or block size
      logic [AW-1:0]  srcStart;
      logic [AW-1:0]  dstStart;
      logic [2:0]     srcStep;     // bytes per unit, 0 keeps address fixed
      logic [2:0]     dstStep;
      logic [ARW-1:0] srcArea;
      logic [ARW-1:0] dstArea;
   } dmcs_cfg_t;

   typedef struct packed {
      logic           valid;
      logic [CHW-1:0] chan;
      logic           write;
      logic [AW-1:0]  addr;
   } dmcs_acc_t;

   typedef struct packed {
      logic [AW-1:0] flashLo;
      logic [AW-1:0] flashHi;
      logic [AW-1:0] sramLo;
      logic [AW-1:0] sramHi;
   } dmcs_secmap_t;

endpackage : dmcs_pkg

/* File: rtl/dmcs_addr_wrap.sv */
// Purpose: next address with extended repeat area wrap
// Assumes: area select already clamped by the caller
// Notes:   purely combinational, one per address side

`timescale 1ns/1ps

module dmcs_addr_wrap (
   input  wire logic [dmcs_pkg::AW-1:0]  addr,
   input  wire logic [2:0]               step,
   input  wire logic [dmcs_pkg::ARW-1:0] area,
   output logic      [dmcs_pkg::AW-1:0]  nextAddr,
   output logic                          overflow
);

   logic [dmcs_pkg::AW-1:0] mask;
   logic [dmcs_pkg::AW-1:0] sum;
   logic                    areaOn;

   // ---------------------------------------------------------------
   // wrap arithmetic
   // ---------------------------------------------------------------
   // upper bits stay fixed, only the window bits roll over
   always_comb begin
      areaOn   = (area != 5'h00);
      mask     = ~(32'hFFFF_FFFF << area);
      sum      = addr + {29'h0000_0000, step};
      nextAddr = areaOn ? ((addr & ~mask) | (sum & mask)) : sum;
      overflow = areaOn && ((sum & ~mask) != (addr & ~mask));
   end

endmodule : dmcs_addr_wrap

/* File: rtl/dmcs_event_sec.sv */
// Purpose: per-channel end, escape, link and error events plus access filter
// Assumes: datapath pulses unitDone once per data unit with its bus response
// Notes:   all event outputs are registered; accViolation stays high while a violating request is held, the others are single-cycle pulses
//
// Notes on behaviour
// RULE_01 - transfer end irq when counter runs out
// RULE_02 - escape irq when repeat size completes
// RULE_03 - escape irq on source area overflow
// RULE_04 - escape irq on destination area overflow
// RULE_05 - shared error irq on any bus error
// RULE_06 - link request per unit, per block
// RULE_07 - non-secure accesses checked before bus
// RULE_08 - per-channel security attribute held
// RULE_09 - module stop halts the block clock
// RULE_10 - wrap keeps upper bits, 2B to 128MB
// RULE_11 - repeat side returns to start address
// RULE_12 - error stops channel, clears activation request
// RULE_13 - every request output one-cycle pulse
// RULE_14 - violation suppressed, handled as transfer error

`timescale 1ns/1ps

module dmcs_event_sec (
   input  wire logic                                     ref_clk,
   input  wire logic                                     rstn,
   input  wire dmcs_pkg::dmcs_cfg_t [dmcs_pkg::NCH-1:0]  chCfg,
   input  wire logic [dmcs_pkg::NCH-1:0]                 chStart,
   input  wire logic [dmcs_pkg::NCH-1:0]                 unitDone,
   input  wire logic [dmcs_pkg::NCH-1:0]                 busErr,
   input  wire dmcs_pkg::dmcs_acc_t                      accReq,
   input  wire dmcs_pkg::dmcs_secmap_t                   secMap,
   input  wire logic                                     moduleStop,
   output logic                                          busReqValid,
   output logic [dmcs_pkg::NCH-1:0]                      chActive,
   output logic [dmcs_pkg::NCH-1:0][dmcs_pkg::AW-1:0]    chSrcAddr,
   output logic [dmcs_pkg::NCH-1:0][dmcs_pkg::AW-1:0]    chDstAddr,
   output logic [dmcs_pkg::NCH-1:0]                      channel_irq,
   output logic [dmcs_pkg::NCH-1:0]                      eventLinkReq,
   output logic [dmcs_pkg::NCH-1:0]                      activationClear,
   output logic                                          transfer_error_irq,
   output logic                                          accViolation,
   output logic                                          moduleClkRun
);

   logic                       stop_q;
   logic                       viol;
   logic [dmcs_pkg::NCH-1:0]   violCh;
   logic [dmcs_pkg::NCH-1:0]   errCh;
   logic [dmcs_pkg::NCH-1:0]   secAttr;
   logic                       errIrq_q;
   logic                       accViol_q;

   // ---------------------------------------------------------------
   // module stop
   // ---------------------------------------------------------------
   // RULE_09 stop state register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         stop_q <= 1'b0;
      end else begin
         stop_q <= moduleStop;
      end
   end

   // clock control gates our clock from this, so it must stay a flop
   assign moduleClkRun = ~stop_q;

   // ---------------------------------------------------------------
   // security filter
   // ---------------------------------------------------------------
   generate
      for (genvar s = 0; s < dmcs_pkg::NCH; s++) begin : g_sec
         // RULE_08 per-channel attribute
         assign secAttr[s] = chCfg[s].secure;
      end
   endgenerate

   // RULE_07 region check, combinational so the bus never sees it
   always_comb begin
      viol = accReq.valid && !secAttr[accReq.chan] &&
             (((accReq.addr >= secMap.flashLo) && (accReq.addr <= secMap.flashHi)) ||
              ((accReq.addr >= secMap.sramLo) && (accReq.addr <= secMap.sramHi)));
      violCh = '0;
      violCh[accReq.chan] = viol;
   end

   // RULE_14 violating access withheld from the bus
   assign busReqValid = accReq.valid && !viol && !stop_q;

   // ---------------------------------------------------------------
   // shared error outputs
   // ---------------------------------------------------------------
   // RULE_05 one error irq for all channels
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         errIrq_q  <= 1'b0;
         accViol_q <= 1'b0;
      end else begin
         errIrq_q  <= |errCh;
         accViol_q <= viol;
      end
   end

   assign transfer_error_irq = errIrq_q;
   assign accViolation       = accViol_q;

   // ---------------------------------------------------------------
   // channels
   // ---------------------------------------------------------------
   generate
      for (genvar i = 0; i < dmcs_pkg::NCH; i++) begin : g_ch
         dmcs_pkg::dmcs_state_t     state_q;
         logic [dmcs_pkg::CW-1:0]   cnt_q;
         logic [dmcs_pkg::SW-1:0]   span_q;
         logic [dmcs_pkg::AW-1:0]   src_q;
         logic [dmcs_pkg::AW-1:0]   dst_q;
         logic [dmcs_pkg::AW-1:0]   srcNext;
         logic [dmcs_pkg::AW-1:0]   dstNext;
         logic [dmcs_pkg::ARW-1:0]  srcArea;
         logic [dmcs_pkg::ARW-1:0]  dstArea;
         logic                      srcOvf;
         logic                      dstOvf;
         logic                      run;
         logic                      beat;
         logic                      spanLast;
         logic                      cntLast;
         logic                      isBlock;
         logic                      isRepeat;
         logic                      endEv;
         logic                      escEv;
         logic                      linkEv;
         logic                      irq_q;
         logic                      link_q;
         logic                      clr_q;

         // RULE_10 area select clamped to 128 Mbytes
         assign srcArea = (chCfg[i].srcArea > dmcs_pkg::AREA_MAX) ?
                          dmcs_pkg::AREA_MAX : chCfg[i].srcArea;
         assign dstArea = (chCfg[i].dstArea > dmcs_pkg::AREA_MAX) ?
                          dmcs_pkg::AREA_MAX : chCfg[i].dstArea;

         // RULE_10 source window wrap
         dmcs_addr_wrap u_src (
            .addr     (src_q),
            .step     (chCfg[i].srcStep),
            .area     (srcArea),
            .nextAddr (srcNext),
            .overflow (srcOvf)
         );

         dmcs_addr_wrap u_dst (
            .addr     (dst_q),
            .step     (chCfg[i].dstStep),
            .area     (dstArea),
            .nextAddr (dstNext),
            .overflow (dstOvf)
         );

         // event qualification for this channel
         always_comb begin
            isBlock  = (chCfg[i].mode == dmcs_pkg::MODE_BLOCK);
            isRepeat = (chCfg[i].mode == dmcs_pkg::MODE_REPEAT);
            run      = (state_q == dmcs_pkg::ST_RUN) && !stop_q;
            errCh[i] = run && ((unitDone[i] && busErr[i]) || violCh[i]);
            beat     = run && unitDone[i] && !errCh[i];
            spanLast = (span_q == dmcs_pkg::SPAN_ONE);
            cntLast  = (cnt_q == dmcs_pkg::CNT_ONE);
            endEv    = beat && !chCfg[i].freeRun && cntLast && (!isBlock || spanLast);
            escEv    = beat && ((isRepeat && spanLast) || srcOvf || dstOvf);
            linkEv   = beat && (!isBlock || spanLast);
         end

         // channel state, errors park the channel until restarted
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               state_q <= dmcs_pkg::ST_IDLE;
            end else begin
               case (state_q)
                  dmcs_pkg::ST_IDLE,
                  dmcs_pkg::ST_HALT: begin
                     if (chStart[i] && !stop_q) begin
                        state_q <= dmcs_pkg::ST_RUN;
                     end
                  end
                  dmcs_pkg::ST_RUN: begin
                     // RULE_12 stop failing channel
                     if (errCh[i]) begin
                        state_q <= dmcs_pkg::ST_HALT;
                     end else if (endEv) begin
                        state_q <= dmcs_pkg::ST_IDLE;
                     end
                  end
                  default: begin
                     state_q <= dmcs_pkg::ST_IDLE;
                  end
               endcase
            end
         end

         // RULE_01 transfer counter, blocks counted in block mode
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               cnt_q <= dmcs_pkg::CNT_RST;
            end else if (chStart[i] && !run) begin
               cnt_q <= chCfg[i].count;
            end else if (beat && !chCfg[i].freeRun && (!isBlock || spanLast)) begin
               cnt_q <= cnt_q - dmcs_pkg::CNT_ONE;
            end
         end

         // RULE_02 repeat and block span counter
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               span_q <= dmcs_pkg::SPAN_RST;
            end else if ((chStart[i] && !run) || (beat && spanLast)) begin
               span_q <= (chCfg[i].span > dmcs_pkg::SPAN_MAX) ?
                         dmcs_pkg::SPAN_MAX : chCfg[i].span;
            end else if (beat) begin
               span_q <= span_q - dmcs_pkg::SPAN_ONE;
            end
         end

         // RULE_11 repeat side back to start address
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               src_q <= dmcs_pkg::ADDR_RST;
               dst_q <= dmcs_pkg::ADDR_RST;
            end else if (chStart[i] && !run) begin
               src_q <= chCfg[i].srcStart;
               dst_q <= chCfg[i].dstStart;
            end else if (beat) begin
               src_q <= (isRepeat && spanLast && chCfg[i].repeatSrc) ?
                        chCfg[i].srcStart : srcNext;
               dst_q <= (isRepeat && spanLast && !chCfg[i].repeatSrc) ?
                        chCfg[i].dstStart : dstNext;
            end
         end

         // RULE_13 registered single-cycle event pulses
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               irq_q  <= 1'b0;
               link_q <= 1'b0;
               clr_q  <= 1'b0;
            end else begin
               // RULE_03 source overflow folded in escEv
               // RULE_04 destination overflow folded in escEv
               irq_q  <= endEv || escEv;
               // RULE_06 link per unit or block
               link_q <= linkEv;
               // RULE_12 ask interrupt control unit to clear
               clr_q  <= errCh[i];
            end
         end

         assign channel_irq[i]     = irq_q;
         assign eventLinkReq[i]    = link_q;
         assign activationClear[i] = clr_q;
         assign chActive[i]        = (state_q == dmcs_pkg::ST_RUN);
         assign chSrcAddr[i]       = src_q;
         assign chDstAddr[i]       = dst_q;
      end
   endgenerate

endmodule : dmcs_event_sec

/* File: tb/dmcs_event_sec_chk.sv */
// Purpose: port-level checks on the dma event and security block
// Assumes: one clock domain, rstn active low
// Notes:   bound to every instance of dmcs_event_sec

`timescale 1ns/1ps

module dmcs_event_sec_chk (
   input wire logic                                    ref_clk,
   input wire logic                                    rstn,
   input wire dmcs_pkg::dmcs_cfg_t [dmcs_pkg::NCH-1:0] chCfg,
   input wire logic [dmcs_pkg::NCH-1:0]                chStart,
   input wire logic [dmcs_pkg::NCH-1:0]                unitDone,
   input wire logic [dmcs_pkg::NCH-1:0]                busErr,
   input wire dmcs_pkg::dmcs_acc_t                     accReq,
   input wire dmcs_pkg::dmcs_secmap_t                  secMap,
   input wire logic                                    moduleStop,
   input wire logic                                    busReqValid,
   input wire logic [dmcs_pkg::NCH-1:0]                chActive,
   input wire logic [dmcs_pkg::NCH-1:0]                channel_irq,
   input wire logic [dmcs_pkg::NCH-1:0]                eventLinkReq,
   input wire logic [dmcs_pkg::NCH-1:0]                activationClear,
   input wire logic                                    transfer_error_irq,
   input wire logic                                    accViolation,
   input wire logic                                    moduleClkRun
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   logic viol;
   // non-secure channel aiming into a secure range, bounds inclusive
   assign viol = accReq.valid && !chCfg[accReq.chan].secure &&
      ((accReq.addr >= secMap.flashLo && accReq.addr <= secMap.flashHi) ||
       (accReq.addr >= secMap.sramLo && accReq.addr <= secMap.sramHi));

   // ---------------------------------------------------------------
   // event, filter, stop and start checks
   // ---------------------------------------------------------------
   a_irq_has_cause: assert property ((channel_irq & ~$past(unitDone & chActive)) == '0)
      else $error("channel irq without a finished unit");
   a_link_has_cause: assert property ((eventLinkReq & ~$past(unitDone & chActive & ~busErr)) == '0)
      else $error("link request without a clean unit");
   a_err_raises_irq: assert property (((unitDone & busErr & chActive) != '0) && moduleClkRun |=> transfer_error_irq)
      else $error("bus error gave no error irq");
   a_err_halts_chan: assert property ((activationClear != '0) |-> ((chActive | channel_irq | eventLinkReq) & activationClear) == '0)
      else $error("erring channel still running or signalling");
   a_filter_blocks: assert property (busReqValid |-> accReq.valid && !viol)
      else $error("violating access reached the bus");
   a_viol_flagged: assert property (viol && moduleClkRun && !moduleStop |=> accViolation)
      else $error("violation not flagged next cycle");
   a_stop_gates_clk: assert property (moduleStop |=> !moduleClkRun)
      else $error("module stop left the clock running");
   a_stop_is_quiet: assert property (!moduleClkRun |=> (channel_irq | eventLinkReq) == '0)
      else $error("events while stopped");
   a_start_runs: assert property (moduleClkRun && !moduleStop && (chStart & ~chActive) != '0 |=> (chActive & $past(chStart & ~chActive)) == $past(chStart & ~chActive))
      else $error("start not taken");

   c_end: cover property (channel_irq[0]);
   c_err: cover property (activationClear[0]);
   c_viol: cover property (accViolation);
endmodule : dmcs_event_sec_chk

bind dmcs_event_sec dmcs_event_sec_chk i_chk (.ref_clk(ref_clk), .rstn(rstn), .chCfg(chCfg),
   .chStart(chStart), .unitDone(unitDone), .busErr(busErr), .accReq(accReq), .secMap(secMap),
   .moduleStop(moduleStop), .busReqValid(busReqValid), .chActive(chActive),
   .channel_irq(channel_irq), .eventLinkReq(eventLinkReq), .activationClear(activationClear),
   .transfer_error_irq(transfer_error_irq), .accViolation(accViolation),
   .moduleClkRun(moduleClkRun));

/* File: tb/dmcs_far_model.sv */
// Purpose: far-side datapath that finishes data units for one channel
// Assumes: go is pulsed only while idle
// Notes:   gap idle cycles between units stand for a slow bus

`timescale 1ns/1ps

module dmcs_far_model (
   input  wire logic                     ref_clk,
   input  wire logic                     rstn,
   input  wire logic                     go,
   input  wire logic [dmcs_pkg::CHW-1:0] goChan,
   input  wire logic [15:0]              goUnits,
   input  wire logic [15:0]              goErrAt,
   input  wire logic [3:0]               gap,
   output logic      [dmcs_pkg::NCH-1:0] unitDone,
   output logic      [dmcs_pkg::NCH-1:0] busErr,
   output logic                          busy
);
   logic [dmcs_pkg::CHW-1:0] chan_q;
   logic [15:0]              left_q;
   logic [15:0]              idx_q;
   logic [3:0]               wait_q;

   // unit sequencer; busErr means nothing without unitDone, so every bit without a unit flips each cycle
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         unitDone <= '0;
         busErr   <= '0;
         busy     <= 1'b0;
         chan_q   <= '0;
         left_q   <= 16'h0000;
         idx_q    <= 16'h0000;
         wait_q   <= 4'h0;
      end else begin
         unitDone <= '0;
         busErr   <= ~busErr;
         if (go) begin
            chan_q <= goChan;
            left_q <= goUnits;
            idx_q  <= 16'h0001;
            wait_q <= gap;
            busy   <= goUnits != 16'h0000;
         end else if (busy && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
         end else if (busy) begin
            unitDone[chan_q] <= 1'b1;
            busErr[chan_q]   <= idx_q == goErrAt;
            idx_q  <= idx_q + 16'h0001;
            left_q <= left_q - 16'h0001;
            wait_q <= gap;
            busy   <= left_q != 16'h0001;
         end
      end
   end
endmodule : dmcs_far_model

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the dma event and security block
// Assumes: channel 0 carries every scenario
// Notes:   pulses are tallied per scenario rather than timed one by one

`timescale 1ns/1ps

module testbench;
   logic                                    ref_clk = 1'b0;
   logic                                    rstn = 1'b0;
   dmcs_pkg::dmcs_cfg_t [dmcs_pkg::NCH-1:0] chCfg = '0;
   logic [dmcs_pkg::NCH-1:0]                chStart = '0;
   dmcs_pkg::dmcs_acc_t                     accReq = '0;
   dmcs_pkg::dmcs_secmap_t                  secMap = {32'h0, 32'h0000_FFFF, 32'h2000_0000, 32'h2000_FFFF};
   logic                                    moduleStop = 1'b0;
   logic                                    go = 1'b0;
   logic [15:0]                             goUnits = 16'h0, goErrAt = 16'h0;
   logic [3:0]                              gap = 4'h0;
   logic [dmcs_pkg::NCH-1:0]                unitDone, busErr, chActive, channel_irq, eventLinkReq;
   logic [dmcs_pkg::NCH-1:0]                activationClear;
   logic [dmcs_pkg::NCH-1:0][dmcs_pkg::AW-1:0] chSrcAddr, chDstAddr;
   logic                                    busy, busReqValid, transfer_error_irq;
   logic                                    accViolation, moduleClkRun;
   int                                      errors = 0, compares = 0;
   int                                      linkCnt, irqCnt, clrCnt, errCnt, violCnt;

   always #12.5 ref_clk = ~ref_clk;

   dmcs_event_sec i_dut (.ref_clk(ref_clk), .rstn(rstn), .chCfg(chCfg), .chStart(chStart),
      .unitDone(unitDone), .busErr(busErr), .accReq(accReq), .secMap(secMap),
      .moduleStop(moduleStop), .busReqValid(busReqValid), .chActive(chActive),
      .chSrcAddr(chSrcAddr), .chDstAddr(chDstAddr), .channel_irq(channel_irq),
      .eventLinkReq(eventLinkReq), .activationClear(activationClear),
      .transfer_error_irq(transfer_error_irq), .accViolation(accViolation),
      .moduleClkRun(moduleClkRun));
   dmcs_far_model i_far (.ref_clk(ref_clk), .rstn(rstn), .go(go), .goChan(3'h0),
      .goUnits(goUnits), .goErrAt(goErrAt), .gap(gap), .unitDone(unitDone), .busErr(busErr),
      .busy(busy));

   // pulse tally for channel 0, cleared by each scenario
   always @(posedge ref_clk) begin
      linkCnt += int'(eventLinkReq[0]);
      irqCnt  += int'(channel_irq[0]);
      clrCnt  += int'(activationClear[0]);
      errCnt  += int'(transfer_error_irq);
      violCnt += int'(accViolation);
   end

   task automatic report_and_stop;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   // channel 0 set up with src step 1 at 0x1000, dst step 2 at 0x2000
   task automatic setup(input dmcs_pkg::dmcs_mode_t m, input logic [15:0] cnt,
                        input logic [10:0] sp, input logic [4:0] sa, input logic [4:0] da);
      chCfg[0] = '0;
      chCfg[0].mode = m;
      chCfg[0].count = cnt;
      chCfg[0].span = sp;
      chCfg[0].srcArea = sa;
      chCfg[0].dstArea = da;
      chCfg[0].secure = 1'b1;
      chCfg[0].repeatSrc = 1'b1;
      chCfg[0].srcStart = 32'h0000_1000;
      chCfg[0].dstStart = 32'h0000_2000;
      chCfg[0].srcStep = 3'h1;
      chCfg[0].dstStep = 3'h2;
      {linkCnt, irqCnt, clrCnt, errCnt, violCnt} = '0;
   endtask : setup

   // start the channel and let the far side finish n units, bounded wait
   task automatic run(input logic [15:0] n, input logic [15:0] errAt, input logic [3:0] g);
      int k;
      goUnits = n;
      goErrAt = errAt;
      gap = g;
      chStart[0] = 1'b1;
      go = 1'b1;
      cyc(1);
      chStart[0] = 1'b0;
      go = 1'b0;
      for (k = 0; k < 500 && busy !== 1'b0; k++) cyc(1);
      if (k == 500) begin
         errors++;
         report_and_stop();
      end
      cyc(3);
   endtask : run

   task automatic t_normal;
      setup(dmcs_pkg::MODE_NORMAL, 16'h0003, 11'h001, 5'h00, 5'h00);
      run(16'h0003, 16'h0000, 4'h0);
      chk("link count", 3, linkCnt);
      chk("end irq", 1, irqCnt);
      chk("active", 0, chActive[0]);
      $display("test normal done");
   endtask : t_normal

   // repeat side taken as destination first, then as source
   task automatic t_repeat;
      for (int r = 0; r < 2; r++) begin
         setup(dmcs_pkg::MODE_REPEAT, 16'h0004, 11'h002, 5'h00, 5'h00);
         chCfg[0].repeatSrc = (r == 1);
         run(16'h0004, 16'h0000, 4'h1);
         chk("escape irq", 2, irqCnt);
         chk("src repeat", (r == 1) ? 32'h0000_1000 : 32'h0000_1004, chSrcAddr[0]);
         chk("dst repeat", (r == 1) ? 32'h0000_2008 : 32'h0000_2000, chDstAddr[0]);
      end
      $display("test repeat done");
   endtask : t_repeat

   // 2-byte window: src wraps every 2 units, dst with step 2 every unit
   task automatic t_area;
      for (int s = 0; s < 2; s++) begin
         setup(dmcs_pkg::MODE_NORMAL, 16'h0005, 11'h001, 5'(s == 0), 5'(s == 1));
         run(16'h0005, 16'h0000, 4'h0);
         chk("wrap irq", (s == 0) ? 3 : 5, irqCnt);
         chk("wrap addr", (s == 0) ? 32'h0000_1001 : 32'h0000_2000,
             (s == 0) ? chSrcAddr[0] : chDstAddr[0]);
      end
      $display("test area done");
   endtask : t_area

   task automatic t_block;
      setup(dmcs_pkg::MODE_BLOCK, 16'h0002, 11'h003, 5'h00, 5'h00);
      run(16'h0006, 16'h0000, 4'h0);
      chk("block link", 2, linkCnt);
      chk("block end", 1, irqCnt);
      $display("test block done");
   endtask : t_block

   // free run: a count of one must not end it before the error
   task automatic t_err;
      setup(dmcs_pkg::MODE_NORMAL, 16'h0001, 11'h001, 5'h00, 5'h00);
      chCfg[0].freeRun = 1'b1;
      run(16'h0004, 16'h0003, 4'h0);
      chk("link before error", 2, linkCnt);
      chk("no end irq", 0, irqCnt);
      chk("activation clear", 1, clrCnt);
      chk("error irq", 1, errCnt);
      chk("halted", 0, chActive[0]);
      $display("test error done");
   endtask : t_err

   task automatic t_viol;
      setup(dmcs_pkg::MODE_NORMAL, 16'h0004, 11'h001, 5'h00, 5'h00);
      accReq = {1'b1, 3'h0, 1'b1, 32'h2000_FFFF};
      #1 chk("secure pass", 1, busReqValid);
      cyc(1);
      chCfg[0].secure = 1'b0;
      accReq.addr = 32'h0001_0000;
      #1 chk("outside pass", 1, busReqValid);
      run(16'h0000, 16'h0000, 4'h0);
      accReq.addr = 32'h2000_FFFF;
      #1 chk("blocked", 0, busReqValid);
      cyc(1);
      accReq.valid = 1'b0;
      cyc(3);
      chk("violation", 1, violCnt);
      chk("viol clear", 1, clrCnt);
      chk("viol error", 1, errCnt);
      $display("test security done");
   endtask : t_viol

   task automatic t_stop;
      setup(dmcs_pkg::MODE_NORMAL, 16'h0002, 11'h001, 5'h00, 5'h00);
      moduleStop = 1'b1;
      accReq = {1'b1, 3'h0, 1'b0, 32'h5000_0000};
      cyc(2);
      chk("clock stopped", 0, moduleClkRun);
      chk("bus held", 0, busReqValid);
      accReq.valid = 1'b0;
      run(16'h0002, 16'h0000, 4'h0);
      chk("stopped link", 0, linkCnt);
      chk("stopped start", 0, chActive[0]);
      moduleStop = 1'b0;
      cyc(3);
      chk("clock back", 1, moduleClkRun);
      $display("test stop done");
   endtask : t_stop

   initial begin
      repeat (12) @(posedge ref_clk);
      #1 rstn = 1'b1;
      cyc(1);
      t_normal();
      t_repeat();
      t_area();
      t_block();
      t_err();
      t_viol();
      t_stop();
      report_and_stop();
   end
endmodule : testbench
